/* File: sim/fault_source.sv */
// Model of the regulators' fault conditions.
module fault_source
	import pdseq_pkg::*;
(
	// Clock and reset.
	input wire logic               clk,
	input wire logic               rst_n,
	// Command: kind, channel, length.
	input wire logic               go,
	input wire logic [1:0]         kind,
	input wire logic [3:0]         chan,
	input wire logic [7:0]         len,
	// Regulator side.
	input wire logic [NUM_REG-1:0] regulator_enable,
	output logic     [NUM_REG-1:0] current_limit_fault,
	output logic     [NUM_REG-1:0] overvoltage_fault,
	output logic     [NUM_REG-1:0] undervoltage_fault
);
	logic [7:0] cnt_q;
	logic [1:0] kind_q;
	logic [3:0] chan_q;
	// An off regulator draws no current and holds no voltage, so its fault ends with it.
	wire logic [NUM_REG-1:0] hit_w = (cnt_q != 8'h00 && regulator_enable[chan_q]) ? 11'h001 << chan_q : 11'h000;
	assign current_limit_fault = (kind_q == 2'h0) ? hit_w : 11'h000;
	assign overvoltage_fault   = (kind_q == 2'h1) ? hit_w : 11'h000;
	assign undervoltage_fault  = (kind_q == 2'h2) ? hit_w : 11'h000;
	// Count down the present fault.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= 8'h00;
			kind_q <= 2'h0;
			chan_q <= 4'h0;
		end else if (go) begin
			cnt_q  <= len;
			kind_q <= kind;
			chan_q <= chan;
		end else if (cnt_q != 8'h00) begin
			cnt_q  <= cnt_q - 8'h01;
		end
	end
endmodule : fault_source

/* File: sim/group_power_down_assertions.sv */
// Port checker for the group power-down sequencer.
module group_power_down_checker
	import pdseq_pkg::*;
(
	// Clock, reset and bus.
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	// Pins.
	input wire logic               power_on_input,
	input wire logic [NUM_REG-1:0] current_limit_fault,
	input wire logic [NUM_REG-1:0] overvoltage_fault,
	input wire logic [NUM_REG-1:0] undervoltage_fault,
	input wire logic [NUM_REG-1:0] regulator_enable,
	input wire logic               host_reset_output_n,
	input wire logic               interrupt_request_pin_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic      [NUM_REG-1:0] en_q;
	wire logic [NUM_REG-1:0] drop_w = en_q & ~regulator_enable;
	wire logic [NUM_REG-1:0] flt_w  = current_limit_fault | overvoltage_fault | undervoltage_fault;
	// Last enables, so a regulator that turns off shows in drop_w for one cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= '0;
		end else begin
			en_q <= regulator_enable;
		end
	end
	// Every gap and lead is longer than eight cycles, so nothing else may drop that soon.
	sequence s_quiet;
		(drop_w == '0) [*8];
	endsequence
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_unmapped_error: assert property (pready && paddr > 8'h2c |-> pslverr) else $error("unmapped not refused");
	a_error_data_zero: assert property (pslverr |-> prdata == '0) else $error("refused read gave data");
	a_gap_quiet: assert property ((|drop_w) && !(|flt_w) |=> s_quiet)
		else $error("group dropped inside gap");
	a_lead_first: assert property ($fell(host_reset_output_n) && drop_w == '0 |=> s_quiet)
		else $error("group dropped inside lead time");
	a_power_on_masked: assert property ($fell(host_reset_output_n) |=> !host_reset_output_n [*8])
		else $error("power on honoured in power down");
	a_trip_has_cause: assert property ((|drop_w) && host_reset_output_n && power_on_input
		|-> (drop_w & ~$past(flt_w, 8)) == '0) else $error("trip without lasting fault");
	a_irq_has_cause: assert property ($fell(interrupt_request_pin_n) |-> $past(|flt_w, 3))
		else $error("interrupt without fault");
endmodule : group_power_down_checker

bind group_power_down group_power_down_checker group_power_down_checker_inst (.clk, .rst_n, .psel, .penable,
	.paddr, .prdata, .pready, .pslverr, .power_on_input, .current_limit_fault, .overvoltage_fault,
	.undervoltage_fault, .regulator_enable, .host_reset_output_n, .interrupt_request_pin_n);

/* File: sim/tb_group_power_down.sv */
// Self-checking bench for the group power-down sequencer.
module tb_group_power_down
	import pdseq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [13:0] v; int d;} note_t;
	localparam int GAPS [4] = '{20, 30, 40, 50};
	localparam logic [25:0] OTP_FLD = {2'h1, 2'h3, {6{2'h3}}, {5{2'h1}}};
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pon = 0, go = 0, pready, pslverr, er;
	logic power_good_pin, host_reset_output_n, interrupt_request_pin_n;
	logic [1:0] kind = 0;
	logic [3:0] chan = 0;
	logic [1:0] otp_lead = 2'h0, otp_post = 2'h1;
	logic [7:0] otp_gap = 8'he4, len = 8'h3c;
	logic [25:0] otp_fld = OTP_FLD;
	logic [7:0] paddr = 0, g;
	logic [25:0] f;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [NUM_REG-1:0] current_limit_fault, overvoltage_fault, undervoltage_fault, regulator_enable;
	logic [13:0] cur = 14'h2000, seen = 14'h2000;
	int fails = 0, checks = 0, seed = 7, cyc = 0, last = 0;
	note_t q[$];
	group_power_down #(.GAP_CYC_0(20), .GAP_CYC_1(30), .GAP_CYC_2(40), .GAP_CYC_3(50), .LEAD_CYC_2(30),
		.LEAD_CYC_3(40), .POST_CYC_1(50), .POST_CYC_2(60), .POST_CYC_3(70), .CURRENT_LIMIT_FAULT_DB_CYC(20), .PERSIST_CYC(25))
		group_power_down_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .power_on_input(pon), .current_limit_fault, .overvoltage_fault, .undervoltage_fault,
		.otp_shutdown_group_field(otp_fld), .otp_group_gap_delay(otp_gap), .otp_reset_lead_time(otp_lead),
		.otp_post_sequence_delay(otp_post), .regulator_enable, .power_good_pin, .host_reset_output_n,
		.interrupt_request_pin_n);
	fault_source fault_source_inst (.clk, .rst_n, .go, .kind, .chan, .len, .regulator_enable,
		.current_limit_fault, .overvoltage_fault, .undervoltage_fault);
	// Clock and cycle count.
	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk_val
	task automatic chk_gap(input int e, input int s);
		checks++;
		if (e >= 0 && s != e && s != e + 1) begin
			fails++;
			$display("wrong value gap expected %0d seen %0d", e, s);
		end
	endtask : chk_gap
	function automatic void note(input int d);
		q.push_back('{cur, d});
	endfunction : note
	// One APB transfer; the request holds until ready is seen.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk_val(n, e, rd);
	endtask : rchk
	task automatic drain;
		int n;
		n = 0;
		while (q.size() != 0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		chk_val("pending notes", 0, q.size());
	endtask : drain
	task automatic fault(input logic [1:0] k, input logic [3:0] c);
		@(posedge clk);
		kind <= k;
		chan <= c;
		len <= 8'h3c + 8'($random(seed) & 63);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		drain;
		repeat (80) @(posedge clk);
	endtask : fault
	// Notes for a power down: groups by code from 00 upward, empty ones skipped.
	function automatic void plan_down(input logic [25:0] fl, input logic [7:0] gp, input int ld);
		int d;
		logic [13:0] m;
		d = -1;
		for (int c = 0; c < 4; c++) begin
			m = '0;
			for (int i = 0; i < NUM_OUT; i++) m[i] = (fl[2*i+:2] == c[1:0]);
			if (m != '0) begin
				if (m[IDX_HRST] && ld != 0) begin
					cur[IDX_HRST] = 1'b0;
					note(d);
					d = ld;
				end
				cur = cur & ~m;
				note(d);
				d = GAPS[gp[2*c+:2]];
			end
		end
	endfunction : plan_down
	// Each output change is matched against the oldest note.
	always @(negedge clk) begin
		if (rst_n && seen !== {interrupt_request_pin_n, host_reset_output_n, power_good_pin, regulator_enable}) begin
			seen = {interrupt_request_pin_n, host_reset_output_n, power_good_pin, regulator_enable};
			if (q.size() == 0) begin
				chk_val("unplanned change", 32'hffffffff, seen);
			end else begin
				chk_val("outputs", q[0].v, seen);
				chk_gap(q[0].d, cyc - last);
				void'(q.pop_front());
			end
			last = cyc;
		end
	end
	task automatic summarize;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	// The run needs under two thousand cycles; this limit of forty thousand only trips on a hang.
	initial begin
		#400us;
		fails++;
		summarize;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rchk("order select", OFS_CTRL, 32'h1);
		rchk("timing", OFS_TIMING, 32'h0);
		apb(1'b1, 8'h40, $random(seed));
		chk_val("unmapped", 1, er);
		cur = 14'h3fff;
		note(-1);
		pon <= 1'b1;
		drain;
		apb(1'b1, OFS_KEEP_IL, ($random(seed) & 32'h7fc) | 32'h2);
		cur[13] = 1'b0;
		note(-1);
		fault(2'h0, 4'h1);
		cur[13] = 1'b1;
		note(-1);
		apb(1'b1, OFS_FLT_IL, 32'h7ff);
		cur[0] = 1'b0;
		cur[13] = 1'b0;
		note(-1);
		fault(2'h0, 4'h0);
		cur[13] = 1'b1;
		note(-1);
		apb(1'b1, OFS_FLT_IL, 32'h7ff);
		apb(1'b1, OFS_INT_MASK, 32'h2);
		cur[2] = 1'b0;
		note(-1);
		fault(2'h1, 4'h2);
		apb(1'b1, OFS_FLT_OV, 32'h7ff);
		apb(1'b1, OFS_CTRL, 32'h7);
		g = $random(seed);
		apb(1'b1, OFS_TIMING, {24'h0, g});
		plan_down(OTP_FLD, g, 0);
		cur = 14'h3fff;
		note(-1);
		pon <= 1'b0;
		otp_fld <= ~OTP_FLD;
		otp_gap <= g;
		otp_lead <= 2'h3;
		otp_post <= 2'h2;
		repeat (8) @(posedge clk);
		pon <= 1'b1;
		drain;
		rchk("keep", OFS_KEEP_IL, 32'h0);
		rchk("group", OFS_GROUP, {6'h0, ~OTP_FLD});
		rchk("timing", OFS_TIMING, {20'h0, 2'h2, 2'h3, g});
		g = $random(seed);
		f = $random(seed);
		f[25:24] = f[1:0];
		f[23:22] = 2'h3;
		apb(1'b1, OFS_GROUP, {6'h0, f});
		apb(1'b1, OFS_TIMING, {22'h0, 2'h2, g});
		plan_down(f, g, 30);
		pon <= 1'b0;
		drain;
		summarize;
	end
endmodule : tb_group_power_down

/* File: verilog/fault_filter.sv */
// Fault debounce and disable decision for one regulator across its three fault types.
module fault_filter
	import pdseq_pkg::*;
#(
	parameter int CURRENT_LIMIT_FAULT_DB_CYC = CURRENT_LIMIT_FAULT_DB_US * CLK_MHZ,
	parameter int PERSIST_CYC = PERSIST_US * CLK_MHZ
) (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Control from the sequencer.
	input  wire logic       monitor,
	input  wire logic       clear,
	// Synchronised fault conditions, order current limit, overvoltage, undervoltage.
	input  wire logic [2:0] fault_in,
	input  wire logic [2:0] keep_on,
	input  wire logic [1:0] over_voltage_debounce,
	input  wire logic [1:0] under_voltage_debounce,
	// Results.
	output logic      [2:0] event_pulse,
	output logic            kill
);

	// Debounce step chosen by a two-bit code.
	function automatic logic [CNT_W-1:0] vdb(input logic [1:0] code);
		case (code)
			2'h0:    vdb = CNT_W'(VDB_CYC_0);
			2'h1:    vdb = CNT_W'(VDB_CYC_1);
			2'h2:    vdb = CNT_W'(VDB_CYC_2);
			default: vdb = CNT_W'(VDB_CYC_3);
		endcase
	endfunction : vdb

	logic [CNT_W-1:0] db_lim   [3];
	logic [CNT_W-1:0] pers_lim [3];
	logic [2:0]       kill_w;

	// Current limit has no persistence window: it trips as soon as it is declared.
	assign db_lim[0]   = CNT_W'(CURRENT_LIMIT_FAULT_DB_CYC);
	assign db_lim[1]   = vdb(over_voltage_debounce);
	assign db_lim[2]   = vdb(under_voltage_debounce);
	assign pers_lim[0] = '0;
	assign pers_lim[1] = CNT_W'(PERSIST_CYC);
	assign pers_lim[2] = CNT_W'(PERSIST_CYC);

	genvar t;
	generate
		for (t = 0; t < 3; t++) begin : g_type
			logic [CNT_W-1:0] db_q;
			logic [CNT_W-1:0] pc_q;
			logic             det_q;
			logic             kill_q;
			wire              active   = monitor & fault_in[t];
			wire              det_d    = active & (det_q | (db_q == db_lim[t] - CNT_W'(1)));
			wire              pers_hit = det_q & ~keep_on[t] & (pc_q == pers_lim[t]);

			// Debounce runs only while the condition holds; any gap restarts it.
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					db_q  <= '0;
					det_q <= 1'b0;
				end else begin
					db_q  <= (active && !det_d) ? db_q + CNT_W'(1) : '0;
					det_q <= det_d;
				end
			end

			// Persistence after detection; a keep-on bit of 1 never trips.
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pc_q   <= '0;
					kill_q <= 1'b0;
				end else begin
					pc_q   <= (det_q && !pers_hit) ? pc_q + CNT_W'(1) : '0;
					kill_q <= ~clear & (kill_q | pers_hit);
				end
			end

			assign event_pulse[t] = det_d & ~det_q;
			assign kill_w[t]      = kill_q | pers_hit;
		end
	endgenerate

	assign kill = |kill_w;

endmodule : fault_filter

/* File: verilog/group_power_down.sv */
// Group-ordered power-down sequencer with per-regulator fault policy and an APB register file.
//
// The placing of the registers and the APB slave port are this design's own decisions.
module group_power_down
	import pdseq_pkg::*;
#(
	parameter int GAP_CYC_0   = GAP_US_0 * CLK_MHZ,
	parameter int GAP_CYC_1   = GAP_US_1 * CLK_MHZ,
	parameter int GAP_CYC_2   = GAP_US_2 * CLK_MHZ,
	parameter int GAP_CYC_3   = GAP_US_3 * CLK_MHZ,
	parameter int LEAD_CYC_2  = LEAD_US_2 * CLK_MHZ,
	parameter int LEAD_CYC_3  = LEAD_US_3 * CLK_MHZ,
	parameter int POST_CYC_1  = POST_US_1 * CLK_MHZ,
	parameter int POST_CYC_2  = POST_US_2 * CLK_MHZ,
	parameter int POST_CYC_3  = POST_US_3 * CLK_MHZ,
	parameter int CURRENT_LIMIT_FAULT_DB_CYC = CURRENT_LIMIT_FAULT_DB_US * CLK_MHZ,
	parameter int PERSIST_CYC = PERSIST_US * CLK_MHZ
) (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// APB slave.
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Pins from outside the clock domain.
	input  wire logic                 power_on_input,
	input  wire logic [NUM_REG-1:0]   current_limit_fault,
	input  wire logic [NUM_REG-1:0]   overvoltage_fault,
	input  wire logic [NUM_REG-1:0]   undervoltage_fault,
	// One-time-programmable default copies, static while powered.
	input  wire logic [FIELD_W-1:0]   otp_shutdown_group_field,
	input  wire logic [7:0]           otp_group_gap_delay,
	input  wire logic [1:0]           otp_reset_lead_time,
	input  wire logic [1:0]           otp_post_sequence_delay,
	// Controlled outputs.
	output logic      [NUM_REG-1:0]   regulator_enable,
	output logic                      power_good_pin,
	output logic                      host_reset_output_n,
	output logic                      interrupt_request_pin_n
);

	// Members of one group: every output whose two-bit field equals the code.
	function automatic logic [NUM_OUT-1:0] members_of(input logic [1:0] code, input logic [FIELD_W-1:0] f);
		for (int i = 0; i < NUM_OUT; i++) begin
			members_of[i] = (f[2*i +: 2] == code);
		end
	endfunction : members_of

	// First non-empty group at or above the start code; bit 2 set means none left.
	function automatic logic [2:0] next_group(input logic [3:0] present, input logic [2:0] from);
		next_group = 3'h4;
		for (int c = 3; c >= 0; c--) begin
			if (present[c] && (3'(c) >= from)) begin
				next_group = 3'(c);
			end
		end
	endfunction : next_group

	// Synchronisers for every pin input.
	logic [3*NUM_REG:0] sync1_q;
	logic [3*NUM_REG:0] sync2_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {undervoltage_fault, overvoltage_fault, current_limit_fault, power_on_input};
			sync2_q <= sync1_q;
		end
	end
	wire pon_s = sync2_q[0];

	// Sequencer and register state.
	state_t               state_q;
	state_t               state_d;
	logic [1:0]           grp_q;
	logic [1:0]           grp_d;
	logic [CNT_W-1:0]     cnt_q;
	logic [CNT_W-1:0]     cnt_d;
	logic [NUM_OUT-1:0]   turn_off;
	logic [NUM_OUT-1:0]   out_on_q;
	logic [2:0]           ctrl_q;
	logic [FIELD_W-1:0]   field_q;
	logic [7:0]           gap_q;
	logic [1:0]           lead_q;
	logic [1:0]           post_q;
	logic [NUM_REG-1:0]   keep_q [3];
	logic [NUM_REG-1:0]   flt_q  [3];
	logic [3:0]           db_q;
	logic [2:0]           mask_q;
	logic [31:0]          prdata_q;
	logic                 pready_q;
	logic                 pslverr_q;
	logic                 irq_n_q;
	logic                 pg_q;
	logic [NUM_REG-1:0]   kill_w;
	logic [2:0]           ev_w [NUM_REG];

	// Group presence and the next group to visit.
	logic [3:0] present;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_present
			assign present[g] = |members_of(2'(g), field_q);
		end
	endgenerate
	wire [2:0]         srch      = next_group(present, (state_q == ST_RUN) ? 3'h0 : {1'b0, grp_q} + 3'h1);
	wire [NUM_OUT-1:0] srch_mem  = members_of(srch[1:0], field_q);
	wire [NUM_OUT-1:0] cur_mem   = members_of(grp_q, field_q);
	wire               lead_first = srch_mem[IDX_HRST] & (lead_q != 2'h0);
	wire               cnt_done  = (cnt_q == '0);
	wire               group_mode = ctrl_q[CTRL_ORDER_BIT];

	// Cycle counts for the selected gap, lead and post delays, minus one for a down-counter.
	wire [1:0] gap_sel = gap_q[2*srch[1:0] +: 2];
	wire [1:0] cur_gap = gap_q[2*grp_q +: 2];
	wire [CNT_W-1:0] gap_load = (cur_gap == 2'h0) ? CNT_W'(GAP_CYC_0 - 1) :
	                            (cur_gap == 2'h1) ? CNT_W'(GAP_CYC_1 - 1) :
	                            (cur_gap == 2'h2) ? CNT_W'(GAP_CYC_2 - 1) : CNT_W'(GAP_CYC_3 - 1);
	wire [CNT_W-1:0] gap_first = (gap_sel == 2'h0) ? CNT_W'(GAP_CYC_0 - 1) :
	                             (gap_sel == 2'h1) ? CNT_W'(GAP_CYC_1 - 1) :
	                             (gap_sel == 2'h2) ? CNT_W'(GAP_CYC_2 - 1) : CNT_W'(GAP_CYC_3 - 1);
	wire [CNT_W-1:0] lead_load = (lead_q == 2'h1) ? CNT_W'(LEAD_CYC_1 - 1) :
	                             (lead_q == 2'h2) ? CNT_W'(LEAD_CYC_2 - 1) : CNT_W'(LEAD_CYC_3 - 1);
	wire [CNT_W-1:0] post_load = (post_q == 2'h1) ? CNT_W'(POST_CYC_1 - 1) :
	                             (post_q == 2'h2) ? CNT_W'(POST_CYC_2 - 1) : CNT_W'(POST_CYC_3 - 1);

	// Next-state logic; the power-on input is read only in off and run, so it is masked meanwhile.
	always_comb begin
		state_d  = state_q;
		grp_d    = grp_q;
		cnt_d    = cnt_done ? cnt_q : cnt_q - CNT_W'(1);
		turn_off = '0;
		unique case (state_q)
			ST_OFF: begin
				if (pon_s) begin
					state_d = ST_PWRUP;
				end
			end
			ST_PWRUP: begin
				state_d = ST_RUN;
			end
			ST_RUN: begin
				if (!pon_s) begin
					if (!group_mode || srch[2]) begin
						// Without group order everything drops at once for the outside sequencer.
						turn_off = '1;
						state_d  = (post_q == 2'h0) ? ST_OFF : ST_POST;
						cnt_d    = post_load;
					end else if (lead_first) begin
						turn_off[IDX_HRST] = 1'b1;
						grp_d   = srch[1:0];
						cnt_d   = lead_load;
						state_d = ST_LEAD;
					end else begin
						turn_off = srch_mem;
						grp_d    = srch[1:0];
						cnt_d    = gap_first;
						state_d  = ST_GAP;
					end
				end
			end
			ST_LEAD: begin
				if (cnt_done) begin
					turn_off = cur_mem;
					cnt_d    = gap_load;
					state_d  = ST_GAP;
				end
			end
			ST_GAP: begin
				if (cnt_done) begin
					if (srch[2]) begin
						state_d = (post_q == 2'h0) ? ST_OFF : ST_POST;
						cnt_d   = post_load;
					end else if (lead_first) begin
						turn_off[IDX_HRST] = 1'b1;
						grp_d   = srch[1:0];
						cnt_d   = lead_load;
						state_d = ST_LEAD;
					end else begin
						turn_off = srch_mem;
						grp_d    = srch[1:0];
						cnt_d    = gap_first;
						state_d  = ST_GAP;
					end
				end
			end
			ST_POST: begin
				if (cnt_done) begin
					state_d = ST_OFF;
				end
			end
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_OFF;
			grp_q   <= GRP_4;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			grp_q   <= grp_d;
			cnt_q   <= cnt_d;
		end
	end

	// Output enables: all on at power up, dropped by the sequence or by a tripped regulator.
	wire [NUM_OUT-1:0] kill_mask = {2'b00, kill_w};
	wire [NUM_OUT-1:0] out_on_d  = (state_q == ST_PWRUP) ? '1 : (out_on_q & ~turn_off & ~kill_mask);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_on_q <= '0;
		end else begin
			out_on_q <= out_on_d;
		end
	end

	// Fault filters, one per regulator, monitoring in power up and run only.
	wire monitor = (state_q == ST_PWRUP) | (state_q == ST_RUN);
	genvar r;
	generate
		for (r = 0; r < NUM_REG; r++) begin : g_reg
			fault_filter #(
				.CURRENT_LIMIT_FAULT_DB_CYC (CURRENT_LIMIT_FAULT_DB_CYC),
				.PERSIST_CYC (PERSIST_CYC)
			) u_filter (
				.clk         (clk),
				.rst_n       (rst_n),
				.monitor     (monitor),
				.clear       (state_q == ST_OFF),
				.fault_in    ({sync2_q[1+2*NUM_REG+r], sync2_q[1+NUM_REG+r], sync2_q[1+r]}),
				.keep_on     ({keep_q[2][r], keep_q[1][r], keep_q[0][r]}),
				.over_voltage_debounce       (db_q[1:0]),
				.under_voltage_debounce       (db_q[3:2]),
				.event_pulse (ev_w[r]),
				.kill        (kill_w[r])
			);
		end
	endgenerate

	// APB decode; one zero-wait access phase, unmapped addresses answer with an error.
	wire setup    = psel & ~penable;
	wire access   = psel & penable & pready_q;
	wire wr       = access & pwrite;
	wire hit_ctrl = (paddr == OFS_CTRL);
	wire hit_grp  = (paddr == OFS_GROUP);
	wire hit_tim  = (paddr == OFS_TIMING);
	wire hit_db   = (paddr == OFS_DEBOUNCE);
	wire hit_mask = (paddr == OFS_INT_MASK);
	wire hit_stat = (paddr == OFS_STATUS);
	wire [2:0] hit_keep = {paddr == OFS_KEEP_UV, paddr == OFS_KEEP_OV, paddr == OFS_KEEP_IL};
	wire [2:0] hit_flt  = {paddr == OFS_FLT_UV, paddr == OFS_FLT_OV, paddr == OFS_FLT_IL};
	wire hit = hit_ctrl | hit_grp | hit_tim | hit_db | hit_mask | hit_stat | (|hit_keep) | (|hit_flt);
	wire [31:0] rd_mux =
		hit_ctrl    ? {29'h0, ctrl_q} :
		hit_grp     ? {6'h0, field_q} :
		hit_tim     ? {20'h0, post_q, lead_q, gap_q} :
		hit_keep[0] ? {21'h0, keep_q[0]} :
		hit_keep[1] ? {21'h0, keep_q[1]} :
		hit_keep[2] ? {21'h0, keep_q[2]} :
		hit_db      ? {28'h0, db_q} :
		hit_flt[0]  ? {21'h0, flt_q[0]} :
		hit_flt[1]  ? {21'h0, flt_q[1]} :
		hit_flt[2]  ? {21'h0, flt_q[2]} :
		hit_mask    ? {29'h0, mask_q} :
		hit_stat    ? {13'h0, out_on_q[NUM_REG-1:0], grp_q, state_q} : 32'h0;

	// Bus answer registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~hit;
			prdata_q  <= (setup && !pwrite) ? rd_mux : '0;
		end
	end

	// Control and working copies; power up reloads the working copies from the OTP defaults over any pending write, but not the control.
	wire pwrup = (state_q == ST_PWRUP);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q  <= CTRL_RST;
			field_q <= '0;
			gap_q   <= '0;
			lead_q  <= '0;
			post_q  <= '0;
		end else if (pwrup) begin
			field_q <= otp_shutdown_group_field;
			gap_q   <= otp_group_gap_delay;
			lead_q  <= otp_reset_lead_time;
			post_q  <= otp_post_sequence_delay;
		end else begin
			if (wr && hit_ctrl) ctrl_q <= pwdata[2:0];
			if (wr && hit_grp) field_q <= pwdata[FIELD_W-1:0];
			if (wr && hit_tim) gap_q <= pwdata[7:0];
			if (wr && hit_tim) lead_q <= pwdata[TIM_LEAD_LSB +: 2];
		end
	end

	// Fault policy settings return to defaults at each power up.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			keep_q <= '{default: KEEP_DEFAULT};
			db_q   <= DB_DEFAULT;
			mask_q <= MASK_DEFAULT;
		end else if (pwrup) begin
			keep_q <= '{default: KEEP_DEFAULT};
			db_q   <= DB_DEFAULT;
			mask_q <= MASK_DEFAULT;
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (wr && hit_keep[k]) keep_q[k] <= pwdata[NUM_REG-1:0];
			end
			if (wr && hit_db) db_q <= pwdata[3:0];
			if (wr && hit_mask) mask_q <= pwdata[2:0];
		end
	end

	// Sticky fault flags, write one to clear; a new event in the clearing cycle wins.
	logic [NUM_REG-1:0] ev_t [3];
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			for (int j = 0; j < NUM_REG; j++) begin
				ev_t[k][j] = ev_w[j][k];
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flt_q <= '{default: '0};
		end else begin
			for (int k = 0; k < 3; k++) begin
				flt_q[k] <= (flt_q[k] & ~((wr && hit_flt[k]) ? pwdata[NUM_REG-1:0] : '0)) | ev_t[k];
			end
		end
	end

	// Interrupt pin low while any unmasked fault flag stands.
	wire irq_any = (|flt_q[0] & ~mask_q[0]) | (|flt_q[1] & ~mask_q[1]) | (|flt_q[2] & ~mask_q[2]);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_n_q <= 1'b1;
		end else begin
			irq_n_q <= ~irq_any;
		end
	end

	// Power-good pin: as a general-purpose output it gives the level bit while its group is on, else it shows run.
	// Built from next values so the pin moves in the same edge as its group, not one later.
	wire pg_d = ctrl_q[CTRL_GPO_BIT] ? (out_on_d[IDX_POWER_GOOD_PIN] & ctrl_q[CTRL_LEVEL_BIT])
	                                 : (out_on_d[IDX_POWER_GOOD_PIN] & (state_d == ST_RUN));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pg_q <= 1'b0;
		end else begin
			pg_q <= pg_d;
		end
	end

	assign regulator_enable        = out_on_q[NUM_REG-1:0];
	assign host_reset_output_n     = out_on_q[IDX_HRST];
	assign power_good_pin          = pg_q;
	assign interrupt_request_pin_n = irq_n_q;
	assign prdata                  = prdata_q;
	assign pready                  = pready_q;
	assign pslverr                 = pslverr_q;

endmodule : group_power_down

/* File: verilog/pdseq_pkg.sv */
// Shared constants, register map and state codes for the group power-down sequencer.
package pdseq_pkg;

	// Output map: eleven regulators, then the power-good pin, then the host reset output.
	localparam int NUM_REG   = 11;
	localparam int NUM_OUT   = 13;
	localparam int IDX_POWER_GOOD_PIN = 11;
	localparam int IDX_HRST  = 12;
	localparam int FIELD_W   = 2 * NUM_OUT;
	localparam int CNT_W     = 20;

	// Clock rate and the documented times in microseconds; cycle counts derive from these.
	localparam int CLK_MHZ      = 100;
	localparam int GAP_US_0     = 120;
	localparam int GAP_US_1     = 250;
	localparam int GAP_US_2     = 500;
	localparam int GAP_US_3     = 1000;
	localparam int LEAD_US_1    = 10;
	localparam int LEAD_US_2    = 100;
	localparam int LEAD_US_3    = 500;
	localparam int POST_US_1    = 1500;
	localparam int POST_US_2    = 5000;
	localparam int POST_US_3    = 10000;
	localparam int CURRENT_LIMIT_FAULT_DB_US   = 1000;
	localparam int PERSIST_US   = 300;
	localparam int LEAD_CYC_1   = LEAD_US_1 * CLK_MHZ;
	// Voltage debounce steps are plain defaults in cycles.
	localparam int VDB_CYC_0    = 8;
	localparam int VDB_CYC_1    = 16;
	localparam int VDB_CYC_2    = 32;
	localparam int VDB_CYC_3    = 64;

	// Group field codes, lowest hierarchy first.
	localparam logic [1:0] GRP_4 = 2'h0;
	localparam logic [1:0] GRP_1 = 2'h3;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_GROUP   = 8'h04;
	localparam logic [7:0] OFS_TIMING  = 8'h08;
	localparam logic [7:0] OFS_KEEP_IL = 8'h0c;
	localparam logic [7:0] OFS_KEEP_OV = 8'h10;
	localparam logic [7:0] OFS_KEEP_UV = 8'h14;
	localparam logic [7:0] OFS_DEBOUNCE = 8'h18;
	localparam logic [7:0] OFS_FLT_IL  = 8'h1c;
	localparam logic [7:0] OFS_FLT_OV  = 8'h20;
	localparam logic [7:0] OFS_FLT_UV  = 8'h24;
	localparam logic [7:0] OFS_INT_MASK = 8'h28;
	localparam logic [7:0] OFS_STATUS  = 8'h2c;

	// Field positions.
	localparam int CTRL_ORDER_BIT = 0;
	localparam int CTRL_GPO_BIT   = 1;
	localparam int CTRL_LEVEL_BIT = 2;
	localparam int TIM_LEAD_LSB   = 8;
	localparam int TIM_POST_LSB   = 10;
	localparam int STAT_GRP_LSB   = 6;
	localparam int STAT_EN_LSB    = 8;

	// Values after reset; all but CTRL_RST are reloaded at each power up.
	localparam logic [2:0]         CTRL_RST     = 3'h1;
	localparam logic [NUM_REG-1:0] KEEP_DEFAULT = 11'h000;
	localparam logic [3:0]         DB_DEFAULT   = 4'h0;
	localparam logic [2:0]         MASK_DEFAULT = 3'h0;

	// Sequencer states.
	typedef enum logic [5:0] {
		ST_OFF   = 6'h01,
		ST_PWRUP = 6'h02,
		ST_RUN   = 6'h04,
		ST_LEAD  = 6'h08,
		ST_GAP   = 6'h10,
		ST_POST  = 6'h20
	} state_t;

endpackage : pdseq_pkg
